/* File: dv/multifunction_pin_config_decode_tb_top.sv */
// Self-checking bench for the pin configuration decoder: every charge pin byte,
// random serial pin bytes and levels, register readback and latency checks.
// Assumes the register port answers reads one cycle later without wait.
module multifunction_pin_config_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic charge_disabled = 1'b0;
  logic [31:0] rdata;
  pin_cfg_pkg::pin_mode_t chg_mode, sw_mode, ecm, esm;
  pin_cfg_pkg::pin_drive_t chg_drive, sw_drive, ecd, esd;
  pin_cfg_pkg::analog_use_t chg_analog, sw_analog, eca, esa;
  logic chg_pin, sw_pin;
  int error_cnt = 0;
  int n_tests = 0;
  logic [31:0] rnd = 32'h45534b18;
  logic [7:0] sw_cfg;
  logic [1:0] oc;

  always #5 clk = !clk;

  multifunction_pin_config_decode multifunction_pin_config_decode_inst (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .charge_disabled(charge_disabled), .chg_mode(chg_mode), .chg_drive(chg_drive),
    .chg_analog(chg_analog), .sw_mode(sw_mode), .sw_drive(sw_drive), .sw_analog(sw_analog)
  );
  pin_load_model pin_load_model_inst (.clk(clk), .drive(chg_drive), .pin_level(chg_pin));
  pin_load_model sw_load_inst (.clk(clk), .drive(sw_drive), .pin_level(sw_pin));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Expected decode of one pin byte; charge_switch_drive selects the charge pin variant
  function automatic void exp_pin(input logic [7:0] c, input logic charge_switch_drive, input logic gl, input logic cd,
      output pin_cfg_pkg::pin_mode_t m, output pin_cfg_pkg::pin_drive_t d, output pin_cfg_pkg::analog_use_t a);
    logic [5:0] o;
    logic lv;
    o = c[7:2];
    m = '0;
    d = '0;
    a = '0;
    d.oe_n = 1'b1;
    case (c[1:0])
      2'h0: m.host_role = !charge_switch_drive;
      2'h1: m.general_output_mode = 1'b1;
      2'h2: m.indicator = charge_switch_drive;
      default: m.analog = 1'b1;
    endcase
    if (m.general_output_mode || m.indicator) begin
      lv = m.general_output_mode ? gl : (cd ^ o[5]); // Polarity only counts for the indicator
      d.drive_out = lv;
      d.rail_upper = o[3];
      d.weak_pu = o[2];
      d.weak_pd = o[0];
      d.oe_n = lv && !o[1] && !o[3];
    end
    if (m.analog) begin
      a.pu_18k = (o[5:4] == 2'h0);
      a.pu_180k = (o[5:4] == 2'h1);
      a.model = o[3:2];
      a.raw_counts = (o[3:2] == 2'h3);
      a.adc_general = (o[1:0] == 2'h0);
      a.cell_prot = (o[1:0] == 2'h1);
      a.switch_prot = (o[1:0] == 2'h3);
      a.report_temp = (o[1:0] != 2'h0);
    end
  endfunction : exp_pin

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // Read data must stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(rdata, e);
    @(posedge clk);
    #1;
    check(rdata, 32'h0);
  endtask : rd

  // Compares all pin outputs and the status word against the expectation
  task automatic check_all(input logic [7:0] c, input logic [7:0] s, input logic [1:0] o);
    exp_pin(c, 1'b1, o[0], charge_disabled, ecm, ecd, eca);
    exp_pin(s, 1'b0, o[1], charge_disabled, esm, esd, esa);
    check(32'({chg_mode, chg_drive, chg_analog}), 32'({ecm, ecd, eca}));
    check(32'({sw_mode, sw_drive, sw_analog}), 32'({esm, esd, esa}));
    if (!ecd.oe_n || (ecd.weak_pu != ecd.weak_pd)) begin
      check(32'(chg_pin), 32'(!ecd.oe_n ? ecd.drive_out : ecd.weak_pu));
    end
    // A lone weak pull must settle a released serial pin as well
    if (!esd.oe_n || (esd.weak_pu != esd.weak_pd)) begin
      check(32'(sw_pin), 32'(!esd.oe_n ? esd.drive_out : esd.weak_pu));
    end
    rd(pin_cfg_pkg::STATUS_OFFSET, {4'h0, esa, eca, esd, ecd});
  endtask : check_all

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  initial begin
    #(pin_cfg_pkg::CLK_PERIOD_NS * 20000);
    error_cnt++;
    results();
  end

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check_all(8'h00, 8'h00, 2'h0);
    rd(pin_cfg_pkg::CHG_CFG_OFFSET, 32'h0);
    rd(pin_cfg_pkg::SW_CFG_OFFSET, 32'h0);
    rd(pin_cfg_pkg::OUT_CTRL_OFFSET, 32'h0);
    // Indicator level follows charge_disabled exactly one edge later
    wr(pin_cfg_pkg::CHG_CFG_OFFSET, 32'h22);
    repeat (2) @(posedge clk);
    charge_disabled <= 1'b1;
    #1;
    check(32'(chg_drive.drive_out), 32'h0);
    @(posedge clk);
    #1;
    check(32'(chg_drive.drive_out), 32'h1);
    // Every charge pin byte, with random serial pin byte, levels and upper data bits
    for (int i = 0; i < 256; i++) begin
      rnd = lfsr_next(rnd);
      sw_cfg = rnd[7:0];
      oc = rnd[9:8];
      wr(pin_cfg_pkg::CHG_CFG_OFFSET, {rnd[31:8], 8'(i)});
      wr(pin_cfg_pkg::SW_CFG_OFFSET, {rnd[23:0], sw_cfg});
      wr(pin_cfg_pkg::OUT_CTRL_OFFSET, {rnd[31:2], oc});
      charge_disabled <= rnd[10];
      repeat (2) @(posedge clk);
      #1;
      check_all(8'(i), sw_cfg, oc);
      rd(pin_cfg_pkg::CHG_CFG_OFFSET, 32'(i));
    end
    // Status is read-only and unmapped space reads zero
    wr(pin_cfg_pkg::STATUS_OFFSET, 32'hffffffff);
    wr(8'h10, 32'hffffffff);
    repeat (2) @(posedge clk);
    #1;
    check_all(8'hff, sw_cfg, oc);
    rd(8'h10, 32'h0);
    rd(pin_cfg_pkg::SW_CFG_OFFSET, 32'(sw_cfg));
    rd(pin_cfg_pkg::OUT_CTRL_OFFSET, 32'(oc));
    // A reset in mid-run must release both pins and clear every setting
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check_all(8'h00, 8'h00, 2'h0);
    rd(pin_cfg_pkg::OUT_CTRL_OFFSET, 32'h0);
    results();
  end
endmodule : multifunction_pin_config_decode_tb_top

/* File: dv/pin_load_model.sv */
// Model of the circuitry hanging on one multifunction pin: resolves the pin level.
// Assumes the drive controls arrive from the decoder on the same clock.
module pin_load_model (
  input wire logic clk,
  input pin_cfg_pkg::pin_drive_t drive,
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // A floating pin must not look like a stable level, so it toggles every cycle
  logic float_q = 1'b0;

  always @(posedge clk) begin
    float_q <= !float_q;
  end

  // Driven level first, then the weak pulls, else the wandering float
  always_comb begin
    if (!drive.oe_n) begin
      pin_level = drive.drive_out;
    end else if (drive.weak_pu) begin
      pin_level = 1'b1;
    end else if (drive.weak_pd) begin
      pin_level = 1'b0;
    end else begin
      pin_level = float_q;
    end
  end
endmodule : pin_load_model

/* File: logic/multifunction_pin_config_decode.sv */
// Top of the multifunction pin configuration decoder: register port, two pin
// configuration bytes, a level control word and registered pin controls.
// Assumes charge_disabled comes from logic on clk and the bus master never
// raises both strobes together.

// Functional notes
// - Charge pin function: unused, output, indicator, analogue
// - Serial pin function: host, output, unused, analogue
// - Indicator polarity bit sets level when disabled
// - Polarity bit ignored in general output mode
// - Rail bit picks 1.8 V or regulator rail
// - Pull-up bit enables weak pull-up to rail
// - Active-high bit; else high is tri-state (the decoder still drives high when the rail bit is set)
// - Pull-down bit enables weak pull-down
// - Analogue function reinterprets the six option bits
// - Pull-up field: 18k, 180k or none
// - Model field: 18K, 180K, custom, raw
// - Measurement: general input, cell, switch protection
// - Code two reports temperature, no protection use
module multifunction_pin_config_decode (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [pin_cfg_pkg::ADDR_W-1:0] addr,
  input wire logic [pin_cfg_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [pin_cfg_pkg::DATA_W-1:0] rdata,
  input wire logic charge_disabled,
  output pin_cfg_pkg::pin_mode_t chg_mode,
  output pin_cfg_pkg::pin_drive_t chg_drive,
  output pin_cfg_pkg::analog_use_t chg_analog,
  output pin_cfg_pkg::pin_mode_t sw_mode,
  output pin_cfg_pkg::pin_drive_t sw_drive,
  output pin_cfg_pkg::analog_use_t sw_analog
);

  typedef struct packed {
    logic [pin_cfg_pkg::CFG_W-1:0] cfg_chg;
    logic [pin_cfg_pkg::CFG_W-1:0] cfg_sw;
    logic [pin_cfg_pkg::OUT_CTRL_W-1:0] out_ctrl;
    logic [pin_cfg_pkg::DATA_W-1:0] rdata;
    pin_cfg_pkg::pin_mode_t chg_mode;
    pin_cfg_pkg::pin_drive_t chg_drive;
    pin_cfg_pkg::analog_use_t chg_analog;
    pin_cfg_pkg::pin_mode_t sw_mode;
    pin_cfg_pkg::pin_drive_t sw_drive;
    pin_cfg_pkg::analog_use_t sw_analog;
  } state_t;

  state_t state_q;
  state_t state_d;

  pin_cfg_pkg::pin_mode_t chg_mode_c;
  pin_cfg_pkg::pin_mode_t sw_mode_c;
  pin_cfg_pkg::analog_use_t chg_analog_c;
  pin_cfg_pkg::analog_use_t sw_analog_c;
  pin_cfg_pkg::pin_drive_t chg_drive_c;
  pin_cfg_pkg::pin_drive_t sw_drive_c;
  logic [pin_cfg_pkg::OPT_W-1:0] chg_opt;
  logic [pin_cfg_pkg::OPT_W-1:0] sw_opt;
  logic [pin_cfg_pkg::FN_W-1:0] chg_fn;
  logic [pin_cfg_pkg::FN_W-1:0] sw_fn;
  logic [pin_cfg_pkg::DATA_W-1:0] status_word;

  // Field views of the stored configuration bytes
  assign chg_opt = state_q.cfg_chg[pin_cfg_pkg::OPT_LSB +: pin_cfg_pkg::OPT_W];
  assign sw_opt = state_q.cfg_sw[pin_cfg_pkg::OPT_LSB +: pin_cfg_pkg::OPT_W];
  assign chg_fn = state_q.cfg_chg[pin_cfg_pkg::FN_LSB +: pin_cfg_pkg::FN_W];
  assign sw_fn = state_q.cfg_sw[pin_cfg_pkg::FN_LSB +: pin_cfg_pkg::FN_W];

  // Charge pin carries the indicator; serial pin has the host role at code 0
  pin_option_decode #(
    .HAS_INDICATOR(1'b1),
    .HAS_HOST_ROLE(1'b0)
  ) chg_decode (
    .cfg(state_q.cfg_chg),
    .mode(chg_mode_c),
    .analog(chg_analog_c)
  );

  pin_option_decode #(
    .HAS_INDICATOR(1'b0),
    .HAS_HOST_ROLE(1'b1)
  ) sw_decode (
    .cfg(state_q.cfg_sw),
    .mode(sw_mode_c),
    .analog(sw_analog_c)
  );

  pin_drive_resolve chg_resolve (
    .mode(chg_mode_c),
    .opt(chg_opt),
    .gpo_level(state_q.out_ctrl[pin_cfg_pkg::OUT_CTRL_CHG_BIT]),
    .charge_disabled(charge_disabled),
    .drive(chg_drive_c)
  );

  // The serial pin has no indicator, so charge state never reaches it
  pin_drive_resolve sw_resolve (
    .mode(sw_mode_c),
    .opt(sw_opt),
    .gpo_level(state_q.out_ctrl[pin_cfg_pkg::OUT_CTRL_SW_BIT]),
    .charge_disabled(1'b0),
    .drive(sw_drive_c)
  );

  // Status shows what the pins are actually doing, not just the settings
  assign status_word = {4'h0, state_q.sw_analog, state_q.chg_analog, state_q.sw_drive, state_q.chg_drive};

  // Next state: register writes, one-cycle read data and pin control copies
  always_comb begin
    state_d = state_q;
    if (wr_en) begin
      case (addr)
        pin_cfg_pkg::CHG_CFG_OFFSET: state_d.cfg_chg = wdata[pin_cfg_pkg::CFG_W-1:0];
        pin_cfg_pkg::SW_CFG_OFFSET: state_d.cfg_sw = wdata[pin_cfg_pkg::CFG_W-1:0];
        pin_cfg_pkg::OUT_CTRL_OFFSET: state_d.out_ctrl = wdata[pin_cfg_pkg::OUT_CTRL_W-1:0];
        default: ; // Status is read-only; unmapped writes vanish
      endcase
    end
    state_d.rdata = '0;
    if (rd_en) begin
      case (addr)
        pin_cfg_pkg::CHG_CFG_OFFSET: state_d.rdata = {24'h000000, state_q.cfg_chg};
        pin_cfg_pkg::SW_CFG_OFFSET: state_d.rdata = {24'h000000, state_q.cfg_sw};
        pin_cfg_pkg::OUT_CTRL_OFFSET: state_d.rdata = {30'h00000000, state_q.out_ctrl};
        pin_cfg_pkg::STATUS_OFFSET: state_d.rdata = status_word;
        default: state_d.rdata = '0;
      endcase
    end
    state_d.chg_mode = chg_mode_c;
    state_d.chg_drive = chg_drive_c;
    state_d.chg_analog = chg_analog_c;
    state_d.sw_mode = sw_mode_c;
    state_d.sw_drive = sw_drive_c;
    state_d.sw_analog = sw_analog_c;
  end

  // Reset releases both pins; a driven pin before software sets it up could fight the board
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= '0;
      state_q.cfg_chg <= pin_cfg_pkg::CFG_RESET;
      state_q.cfg_sw <= pin_cfg_pkg::CFG_RESET;
      state_q.out_ctrl <= pin_cfg_pkg::OUT_CTRL_RESET;
      state_q.chg_drive.oe_n <= 1'b1;
      state_q.sw_drive.oe_n <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flops
  assign rdata = state_q.rdata;
  assign chg_mode = state_q.chg_mode;
  assign chg_drive = state_q.chg_drive;
  assign chg_analog = state_q.chg_analog;
  assign sw_mode = state_q.sw_mode;
  assign sw_drive = state_q.sw_drive;
  assign sw_analog = state_q.sw_analog;

  // Checks on the registered pin controls and read data, all one cycle behind their cause
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence chg_ind_cut_s;
    chg_fn == pin_cfg_pkg::FN_ALT && charge_disabled;
  endsequence

  sequence chg_out_fn_s;
    chg_fn == pin_cfg_pkg::FN_GPO || chg_fn == pin_cfg_pkg::FN_ALT;
  endsequence

  // Code 2 is unused on the serial pin, so only the general output drives it
  sequence sw_out_fn_s;
    sw_fn == pin_cfg_pkg::FN_GPO;
  endsequence

  sequence sw_analog_s;
    sw_fn == pin_cfg_pkg::FN_ANALOG;
  endsequence

  chg_fn_decode_a: assert property (
    1'b1 |=> chg_mode.indicator == ($past(chg_fn) == pin_cfg_pkg::FN_ALT)
      && chg_mode.general_output_mode == ($past(chg_fn) == pin_cfg_pkg::FN_GPO)
      && chg_mode.analog == ($past(chg_fn) == pin_cfg_pkg::FN_ANALOG) && !chg_mode.host_role)
    else $error("charge pin function decode wrong");

  sw_fn_decode_a: assert property (
    1'b1 |=> sw_mode.host_role == ($past(sw_fn) == pin_cfg_pkg::FN_IDLE)
      && !sw_mode.indicator && sw_mode.general_output_mode == ($past(sw_fn) == pin_cfg_pkg::FN_GPO))
    else $error("serial pin function decode wrong");

  ind_polarity_a: assert property (
    chg_ind_cut_s |=> chg_drive.drive_out == !$past(chg_opt[pin_cfg_pkg::OPT_POLARITY]))
    else $error("indicator level wrong while charging disabled");

  gpo_ignores_pol_a: assert property (
    chg_fn == pin_cfg_pkg::FN_GPO |=> chg_drive.drive_out == $past(state_q.out_ctrl[pin_cfg_pkg::OUT_CTRL_CHG_BIT]))
    else $error("general output level disturbed");

  rail_select_a: assert property (
    chg_out_fn_s |=> chg_drive.rail_upper == $past(chg_opt[pin_cfg_pkg::OPT_RAIL]))
    else $error("high-drive rail select wrong");

  weak_pull_up_a: assert property (
    chg_out_fn_s |=> chg_drive.weak_pu == $past(chg_opt[pin_cfg_pkg::OPT_PULL_UP]))
    else $error("weak pull-up wrong");

  tristate_high_a: assert property (
    chg_out_fn_s ##1 chg_drive.drive_out |-> chg_drive.oe_n ==
      !($past(chg_opt[pin_cfg_pkg::OPT_ACTIVE_HI]) || $past(chg_opt[pin_cfg_pkg::OPT_RAIL])))
    else $error("high drive versus tri-state wrong");

  weak_pull_down_a: assert property (
    chg_out_fn_s |=> chg_drive.weak_pd == $past(chg_opt[pin_cfg_pkg::OPT_PULL_DOWN]))
    else $error("weak pull-down wrong");

  analog_quiet_a: assert property (
    chg_fn == pin_cfg_pkg::FN_ANALOG |=> chg_drive.oe_n && !chg_drive.weak_pu && !chg_drive.weak_pd)
    else $error("analogue pin still uses output options");

  pull_up_sel_a: assert property (
    chg_fn == pin_cfg_pkg::FN_ANALOG
      |=> chg_analog.pu_18k == ($past(chg_opt[pin_cfg_pkg::PU_LSB +: 2]) == pin_cfg_pkg::PU_18K)
      && chg_analog.pu_180k == ($past(chg_opt[pin_cfg_pkg::PU_LSB +: 2]) == pin_cfg_pkg::PU_180K))
    else $error("pull-up selection wrong");

  model_sel_a: assert property (
    chg_fn == pin_cfg_pkg::FN_ANALOG |=> chg_analog.model == $past(chg_opt[pin_cfg_pkg::MODEL_LSB +: 2])
      && chg_analog.raw_counts == ($past(chg_opt[pin_cfg_pkg::MODEL_LSB +: 2]) == pin_cfg_pkg::MODEL_RAW))
    else $error("temperature model selection wrong");

  meas_use_a: assert property (
    chg_fn == pin_cfg_pkg::FN_ANALOG && chg_opt[pin_cfg_pkg::MEAS_LSB +: 2] == pin_cfg_pkg::MEAS_SWITCH
      |=> chg_analog.switch_prot && !chg_analog.cell_prot && !chg_analog.adc_general)
    else $error("switch protection use wrong");

  report_only_a: assert property (
    chg_fn == pin_cfg_pkg::FN_ANALOG && chg_opt[pin_cfg_pkg::MEAS_LSB +: 2] == pin_cfg_pkg::MEAS_REPORT
      |=> chg_analog.report_temp && !chg_analog.cell_prot && !chg_analog.switch_prot)
    else $error("report-only thermistor used for protection");

  read_back_a: assert property (
    rd_en && addr == pin_cfg_pkg::CHG_CFG_OFFSET |=> rdata[pin_cfg_pkg::CFG_W-1:0] == $past(state_q.cfg_chg)
      ##1 rdata == '0 || $past(rd_en))
    else $error("configuration read-back wrong");

  sw_read_back_a: assert property (
    rd_en && addr == pin_cfg_pkg::SW_CFG_OFFSET |=> rdata == {24'h000000, $past(state_q.cfg_sw)})
    else $error("serial pin configuration read-back wrong");

  // Reset must release both pins by the next edge, so this check keeps running through reset
  pins_released_a: assert property (disable iff (1'b0)
    !reset_n |=> chg_drive.oe_n && sw_drive.oe_n && !chg_drive.weak_pu && !sw_drive.weak_pu)
    else $error("pin not released after reset");

  chg_idle_quiet_a: assert property (
    chg_fn == pin_cfg_pkg::FN_IDLE |=> chg_mode == '0 && chg_drive.oe_n && !chg_drive.weak_pu && !chg_drive.weak_pd)
    else $error("unused charge pin not released");

  sw_unused_quiet_a: assert property (
    sw_fn == pin_cfg_pkg::FN_ALT |=> sw_mode == '0 && sw_drive.oe_n && !sw_drive.weak_pu && !sw_drive.weak_pd)
    else $error("unused serial pin not released");

  ind_idle_level_a: assert property (
    chg_fn == pin_cfg_pkg::FN_ALT && !charge_disabled
      |=> chg_drive.drive_out == $past(chg_opt[pin_cfg_pkg::OPT_POLARITY]))
    else $error("indicator level wrong while charging allowed");

  sw_gpo_level_a: assert property (
    sw_out_fn_s |=> sw_drive.drive_out == $past(state_q.out_ctrl[pin_cfg_pkg::OUT_CTRL_SW_BIT]))
    else $error("serial pin output level disturbed");

  sw_rail_select_a: assert property (
    sw_out_fn_s |=> sw_drive.rail_upper == $past(sw_opt[pin_cfg_pkg::OPT_RAIL]))
    else $error("serial pin rail select wrong");

  sw_weak_pull_up_a: assert property (
    sw_out_fn_s |=> sw_drive.weak_pu == $past(sw_opt[pin_cfg_pkg::OPT_PULL_UP]))
    else $error("serial pin weak pull-up wrong");

  drive_low_a: assert property (
    chg_out_fn_s ##1 !chg_drive.drive_out |-> !chg_drive.oe_n)
    else $error("low level not actively driven");

  sw_tristate_a: assert property (
    sw_out_fn_s ##1 sw_drive.drive_out |-> sw_drive.oe_n ==
      !($past(sw_opt[pin_cfg_pkg::OPT_ACTIVE_HI]) || $past(sw_opt[pin_cfg_pkg::OPT_RAIL])))
    else $error("serial pin high drive versus tri-state wrong");

  sw_weak_pull_down_a: assert property (
    sw_out_fn_s |=> sw_drive.weak_pd == $past(sw_opt[pin_cfg_pkg::OPT_PULL_DOWN]))
    else $error("serial pin weak pull-down wrong");

  sw_analog_quiet_a: assert property (
    sw_analog_s |=> sw_mode.analog && sw_drive.oe_n && !sw_drive.weak_pu && !sw_drive.weak_pd)
    else $error("analogue serial pin still uses output options");

  no_analog_use_a: assert property (
    1'b1 |=> (chg_analog == '0 || $past(chg_fn) == pin_cfg_pkg::FN_ANALOG)
      && (sw_analog == '0 || $past(sw_fn) == pin_cfg_pkg::FN_ANALOG))
    else $error("analogue fields set outside analogue function");

  no_pull_sel_a: assert property (
    chg_fn == pin_cfg_pkg::FN_ANALOG && chg_opt[pin_cfg_pkg::PU_LSB +: 2] != pin_cfg_pkg::PU_18K
      && chg_opt[pin_cfg_pkg::PU_LSB +: 2] != pin_cfg_pkg::PU_180K |=> !chg_analog.pu_18k && !chg_analog.pu_180k)
    else $error("pull-up chosen where none is wanted");

  sw_pull_up_sel_a: assert property (
    sw_analog_s |=> sw_analog.pu_18k == ($past(sw_opt[pin_cfg_pkg::PU_LSB +: 2]) == pin_cfg_pkg::PU_18K)
      && sw_analog.pu_180k == ($past(sw_opt[pin_cfg_pkg::PU_LSB +: 2]) == pin_cfg_pkg::PU_180K))
    else $error("serial pin pull-up selection wrong");

  sw_model_sel_a: assert property (
    sw_analog_s |=> sw_analog.model == $past(sw_opt[pin_cfg_pkg::MODEL_LSB +: 2])
      && sw_analog.raw_counts == ($past(sw_opt[pin_cfg_pkg::MODEL_LSB +: 2]) == pin_cfg_pkg::MODEL_RAW))
    else $error("serial pin temperature model wrong");

  meas_cell_a: assert property (
    chg_fn == pin_cfg_pkg::FN_ANALOG && chg_opt[pin_cfg_pkg::MEAS_LSB +: 2] == pin_cfg_pkg::MEAS_CELL
      |=> chg_analog.cell_prot && !chg_analog.switch_prot && !chg_analog.adc_general && chg_analog.report_temp)
    else $error("cell protection use wrong");

  meas_general_a: assert property (
    chg_fn == pin_cfg_pkg::FN_ANALOG && chg_opt[pin_cfg_pkg::MEAS_LSB +: 2] == pin_cfg_pkg::MEAS_ADC
      |=> chg_analog.adc_general && !chg_analog.cell_prot && !chg_analog.switch_prot && !chg_analog.report_temp)
    else $error("general analogue input use wrong");

endmodule : multifunction_pin_config_decode

/* File: logic/pin_cfg_pkg.sv */
// Shared constants and carriers for the multifunction pin configuration decoder.
// Assumes one 100 MHz clock and a plain strobe register port with 32-bit data.
package pin_cfg_pkg;

  // Bus geometry and timing of the register port
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Register offsets (byte addresses, one aligned word each)
  localparam logic [ADDR_W-1:0] CHG_CFG_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] SW_CFG_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] OUT_CTRL_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h0c;

  // Configuration byte layout: function field in the low bits, options above
  localparam int unsigned CFG_W = 8;
  localparam int unsigned FN_LSB = 0;
  localparam int unsigned FN_W = 2;
  localparam int unsigned OPT_LSB = 2;
  localparam int unsigned OPT_W = 6;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

  // Option bit positions in output functions
  localparam int unsigned OPT_POLARITY = 5;
  localparam int unsigned OPT_RAIL = 3;
  localparam int unsigned OPT_PULL_UP = 2;
  localparam int unsigned OPT_ACTIVE_HI = 1;
  localparam int unsigned OPT_PULL_DOWN = 0;

  // Option field positions in analogue functions
  localparam int unsigned PU_LSB = 4;
  localparam int unsigned MODEL_LSB = 2;
  localparam int unsigned MEAS_LSB = 0;

  // Analogue option codes
  localparam logic [1:0] PU_18K = 2'h0;
  localparam logic [1:0] PU_180K = 2'h1;
  localparam logic [1:0] MODEL_RAW = 2'h3;
  localparam logic [1:0] MEAS_ADC = 2'h0;
  localparam logic [1:0] MEAS_CELL = 2'h1;
  localparam logic [1:0] MEAS_REPORT = 2'h2;
  localparam logic [1:0] MEAS_SWITCH = 2'h3;

  // Output-level control register
  localparam int unsigned OUT_CTRL_W = 2;
  localparam int unsigned OUT_CTRL_CHG_BIT = 0;
  localparam int unsigned OUT_CTRL_SW_BIT = 1;
  localparam logic [OUT_CTRL_W-1:0] OUT_CTRL_RESET = 2'h0;

  // Function field codes; code 2 is the indicator on one pin, unused on the other
  typedef enum logic [1:0] {
    FN_IDLE = 2'h0,
    FN_GPO = 2'h1,
    FN_ALT = 2'h2,
    FN_ANALOG = 2'h3
  } pin_func_t;

  typedef struct packed {
    logic host_role;
    logic general_output_mode;
    logic indicator;
    logic analog;
  } pin_mode_t;

  typedef struct packed {
    logic pu_18k;
    logic pu_180k;
    logic [1:0] model;
    logic raw_counts;
    logic adc_general;
    logic cell_prot;
    logic switch_prot;
    logic report_temp;
  } analog_use_t;

  typedef struct packed {
    logic drive_out;
    logic oe_n;
    logic rail_upper; // High drive from the regulator rail instead of 1.8 V
    logic weak_pu;
    logic weak_pd;
  } pin_drive_t;

endpackage : pin_cfg_pkg

/* File: logic/pin_drive_resolve.sv */
// Turns a decoded output function and its options into pin drive controls.
// Purely combinational; the charge-disable level comes from logic on the same clock.
module pin_drive_resolve (
  input pin_cfg_pkg::pin_mode_t mode,
  input wire logic [pin_cfg_pkg::OPT_W-1:0] opt,
  input wire logic gpo_level,
  input wire logic charge_disabled,
  output pin_cfg_pkg::pin_drive_t drive
);

  logic level;

  // Polarity only applies to the indicator; a plain output follows software
  assign level = mode.indicator ? (charge_disabled ^ opt[pin_cfg_pkg::OPT_POLARITY])
                                : gpo_level;

  // Non-output functions leave the pin released with no pulls
  always_comb begin
    drive = '0;
    drive.oe_n = 1'b1;
    if (mode.general_output_mode || mode.indicator) begin
      drive.drive_out = level;
      drive.rail_upper = opt[pin_cfg_pkg::OPT_RAIL];
      drive.weak_pu = opt[pin_cfg_pkg::OPT_PULL_UP];
      drive.weak_pd = opt[pin_cfg_pkg::OPT_PULL_DOWN];
      // The upper rail has no tri-state high, so it always drives
      drive.oe_n = level && !(opt[pin_cfg_pkg::OPT_ACTIVE_HI] || opt[pin_cfg_pkg::OPT_RAIL]);
    end
  end

endmodule : pin_drive_resolve

/* File: logic/pin_option_decode.sv */
// Splits one pin configuration byte into its function and analogue fields.
// Purely combinational; the caller registers the results.
module pin_option_decode #(
  parameter bit HAS_INDICATOR = 1'b1,
  parameter bit HAS_HOST_ROLE = 1'b0
) (
  input wire logic [pin_cfg_pkg::CFG_W-1:0] cfg,
  output pin_cfg_pkg::pin_mode_t mode,
  output pin_cfg_pkg::analog_use_t analog
);

  pin_cfg_pkg::pin_func_t fn;
  logic [pin_cfg_pkg::OPT_W-1:0] opt;
  logic [1:0] pu;
  logic [1:0] meas;

  assign fn = pin_cfg_pkg::pin_func_t'(cfg[pin_cfg_pkg::FN_LSB +: pin_cfg_pkg::FN_W]);
  assign opt = cfg[pin_cfg_pkg::OPT_LSB +: pin_cfg_pkg::OPT_W];
  assign pu = opt[pin_cfg_pkg::PU_LSB +: 2];
  assign meas = opt[pin_cfg_pkg::MEAS_LSB +: 2];

  // Options only mean analogue settings once the analogue function is chosen
  always_comb begin
    mode = '0;
    analog = '0;
    unique case (fn)
      pin_cfg_pkg::FN_IDLE: mode.host_role = HAS_HOST_ROLE;
      pin_cfg_pkg::FN_GPO: mode.general_output_mode = 1'b1;
      pin_cfg_pkg::FN_ALT: mode.indicator = HAS_INDICATOR; // Unused on the serial pin
      pin_cfg_pkg::FN_ANALOG: begin
        mode.analog = 1'b1;
        analog.pu_18k = (pu == pin_cfg_pkg::PU_18K);
        analog.pu_180k = (pu == pin_cfg_pkg::PU_180K); // Codes 2 and 3 are left without pull-up
        analog.model = opt[pin_cfg_pkg::MODEL_LSB +: 2];
        analog.raw_counts = (opt[pin_cfg_pkg::MODEL_LSB +: 2] == pin_cfg_pkg::MODEL_RAW);
        analog.adc_general = (meas == pin_cfg_pkg::MEAS_ADC);
        analog.cell_prot = (meas == pin_cfg_pkg::MEAS_CELL);
        analog.switch_prot = (meas == pin_cfg_pkg::MEAS_SWITCH);
        analog.report_temp = (meas != pin_cfg_pkg::MEAS_ADC);
      end
    endcase
  end

endmodule : pin_option_decode
